// ==== verilog/rmon_pkg.sv ====
// Package: register map, field positions and types of the regulator monitor
package rmon_pkg;
  // Register indices (printed offsets are not word multiples); byte address = 4 * index
  localparam logic [11:0] IDX_TEMP_CTRL = 12'h2f0;
  localparam logic [11:0] IDX_LV_CTRL = 12'h2f1;
  localparam logic [11:0] IDX_PER_CTRL = 12'h2f2;
  localparam logic [11:0] IDX_PER_TRIM = 12'h2f3;
  localparam logic [11:0] IDX_RATE_HI = 12'h2f4;
  localparam logic [11:0] IDX_RATE_LO = 12'h2f5;
  localparam logic [11:0] IDX_RSVD = 12'h2f6;
  localparam logic [11:0] IDX_TEMP_TRIM = 12'h2f7;
  // Extra registers: mode/event status and interrupt mask
  localparam logic [11:0] IDX_EVT_STATUS = 12'h2f8;
  localparam logic [11:0] IDX_EVT_MASK = 12'h2f9;
  // Field positions
  localparam int FLAG_BIT = 0;
  localparam int IRQEN_BIT = 1;
  localparam int STATUS_BIT = 2;
  localparam int SENSE_EN_BIT = 3;
  localparam int ROUTE_EN_BIT = 4;
  localparam int SRC_SEL_BIT = 5;
  localparam int TEST_LO_BIT = 6;
  localparam int TEST_HI_BIT = 7;
  // Reset values
  localparam logic [7:0] TEMP_CTRL_RESET = 8'h10;
  localparam logic [7:0] LV_CTRL_RESET = 8'h00;
  localparam logic [7:0] PER_CTRL_RESET = 8'h00;
  localparam logic [7:0] PER_TRIM_RESET = 8'h00;
  localparam logic [7:0] RATE_RESET = 8'h00;
  localparam logic [7:0] TEMP_TRIM_RESET = 8'h00;
  localparam logic [1:0] EVT_MASK_RESET = 2'h3;
  // Writable masks for the plain storage registers
  localparam logic [7:0] PER_CTRL_WMASK = 8'h9f;
  localparam logic [7:0] PER_TRIM_WMASK = 8'hfc;
  localparam logic [7:0] TEMP_TRIM_WMASK = 8'h8f;

  typedef enum logic [1:0] {MODE_FULL, MODE_REDUCED, MODE_SHUTDOWN} rmon_mode_t;

  // Analog comparator levels
  typedef struct packed {
    logic overTemp;
    logic underVoltage;
  } rmon_cmp_t;

  // Analog routing to the converter channel
  typedef struct packed {
    logic voltageRouteEnable;
    logic voltageSourceSelect;
    logic tempSenseEnable;
  } rmon_route_t;
endpackage

// ==== verilog/rmon_regs.sv ====
// Regulator monitor register bank with APB slave and event flags
//
// Contract
// - temperature status read-only, live only in full mode
// - temperature status change sets temperature flag
// - flags clear only by writing one
// - temperature flag and enable raise request
// - reduced power keeps temperature flag
// - sense enable bit switches sensing on
// - source select picks proportional or bandgap
// - route enable connects selected voltage
// - test bits writable only in test mode
// - undervoltage status read-only, live only full mode
// - undervoltage status change sets its flag
// - undervoltage flag and enable raise request
// - reduced power keeps undervoltage flag
// - detectors disabled in reduced power, shutdown
// - shutdown while regulator enable input low
`timescale 1ns/1ps
module rmon_regs (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Device context (asynchronous pins)
  input wire logic regulator_enable_input,
  input wire logic stopMode,
  input wire logic testMode,
  input wire rmon_pkg::rmon_cmp_t cmpRaw,
  // Analog control
  output rmon_pkg::rmon_route_t route,
  output logic [1:0] detectorEnable,
  // Interrupts
  output logic overTempIrq,
  output logic underVoltageIrq,
  output logic irq
);

  // Two-stage synchronisers for pins and comparators
  logic [4:0] sync1;
  logic [4:0] sync2;
  always_ff @(posedge clk) begin
    if (srst) begin
      sync1 <= 5'h00;
      sync2 <= 5'h00;
    end else begin
      sync1 <= {regulator_enable_input, stopMode, testMode, cmpRaw.overTemp,
        cmpRaw.underVoltage};
      sync2 <= sync1;
    end
  end

  logic regEnS;
  logic stopS;
  logic testS;
  logic overTempS;
  logic underVoltS;
  assign regEnS = sync2[4];
  assign stopS = sync2[3];
  assign testS = sync2[2];
  assign overTempS = sync2[1];
  assign underVoltS = sync2[0];

  // Operating mode
  rmon_pkg::rmon_mode_t mode;
  always_comb begin
    if (!regEnS) begin
      mode = rmon_pkg::MODE_SHUTDOWN;
    end else if (stopS) begin
      mode = rmon_pkg::MODE_REDUCED;
    end else begin
      mode = rmon_pkg::MODE_FULL;
    end
  end

  logic fullMode;
  assign fullMode = (mode == rmon_pkg::MODE_FULL);

  // Control storage
  logic [7:0] tempCtrl;
  logic lvIrqEnable;
  logic [7:0] perCtrl;
  logic [7:0] perTrim;
  logic [7:0] rateHi;
  logic [7:0] rateLo;
  logic [7:0] tempTrim;
  logic [1:0] evtMask;
  logic overTempFlag;
  logic underVoltageFlag;
  logic overTempStatus;
  logic underVoltageStatus;
  logic prevOverTemp;
  logic prevUnderVolt;

  // APB decode: one-wait-free access, byte address = 4 * index
  logic access;
  logic wrEn;
  logic addrOk;
  logic [11:0] regIdx;
  logic [7:0] wByte;
  assign access = psel && penable;
  assign regIdx = paddr[13:2];
  assign addrOk = (paddr[1:0] == 2'h0) && (paddr[15:14] == 2'h0)
    && (regIdx >= rmon_pkg::IDX_TEMP_CTRL) && (regIdx <= rmon_pkg::IDX_EVT_MASK)
    && (regIdx != rmon_pkg::IDX_RSVD);
  assign wrEn = access && pwrite && addrOk && pstrb[0];
  assign wByte = pwdata[7:0];
  assign pready = 1'b1;
  // Reserved slot aborts, like any unmapped address
  assign pslverr = access && !addrOk;

  // Detector gating
  logic tempSenseOn;
  assign tempSenseOn = tempCtrl[rmon_pkg::SENSE_EN_BIT] && fullMode;
  assign detectorEnable = {tempSenseOn, fullMode};

  // Status bits driven from comparators only
  always_ff @(posedge clk) begin
    if (srst) begin
      overTempStatus <= 1'b0;
      underVoltageStatus <= 1'b0;
    end else begin
      overTempStatus <= overTempS && tempSenseOn;
      underVoltageStatus <= underVoltS && fullMode;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      prevOverTemp <= 1'b0;
      prevUnderVolt <= 1'b0;
    end else begin
      prevOverTemp <= overTempStatus;
      prevUnderVolt <= underVoltageStatus;
    end
  end

  logic overTempChange;
  logic underVoltChange;
  assign overTempChange = overTempStatus ^ prevOverTemp;
  assign underVoltChange = underVoltageStatus ^ prevUnderVolt;

  logic clrOverTemp;
  logic clrUnderVolt;
  assign clrOverTemp = wrEn && (regIdx == rmon_pkg::IDX_TEMP_CTRL)
    && wByte[rmon_pkg::FLAG_BIT];
  assign clrUnderVolt = wrEn && (regIdx == rmon_pkg::IDX_LV_CTRL)
    && wByte[rmon_pkg::FLAG_BIT];

  // Flags: set wins over a clear in the same cycle so no edge is lost
  always_ff @(posedge clk) begin
    if (srst) begin
      overTempFlag <= 1'b0;
      underVoltageFlag <= 1'b0;
    end else begin
      if (overTempChange) begin
        overTempFlag <= 1'b1;
      end else if (clrOverTemp) begin
        overTempFlag <= 1'b0;
      end
      if (underVoltChange) begin
        underVoltageFlag <= 1'b1;
      end else if (clrUnderVolt) begin
        underVoltageFlag <= 1'b0;
      end
    end
  end

  // Control register writes
  always_ff @(posedge clk) begin
    if (srst) begin
      tempCtrl <= rmon_pkg::TEMP_CTRL_RESET;
      lvIrqEnable <= 1'b0;
      evtMask <= rmon_pkg::EVT_MASK_RESET;
    end else if (wrEn) begin
      case (regIdx)
        rmon_pkg::IDX_TEMP_CTRL: begin
          tempCtrl[rmon_pkg::SRC_SEL_BIT] <= wByte[rmon_pkg::SRC_SEL_BIT];
          tempCtrl[rmon_pkg::ROUTE_EN_BIT] <= wByte[rmon_pkg::ROUTE_EN_BIT];
          tempCtrl[rmon_pkg::SENSE_EN_BIT] <= wByte[rmon_pkg::SENSE_EN_BIT];
          tempCtrl[rmon_pkg::IRQEN_BIT] <= wByte[rmon_pkg::IRQEN_BIT];
          // test bits gated by test mode
          if (testS) begin
            tempCtrl[rmon_pkg::TEST_HI_BIT] <= wByte[rmon_pkg::TEST_HI_BIT];
            tempCtrl[rmon_pkg::TEST_LO_BIT] <= wByte[rmon_pkg::TEST_LO_BIT];
          end
        end
        rmon_pkg::IDX_LV_CTRL: begin
          lvIrqEnable <= wByte[rmon_pkg::IRQEN_BIT];
        end
        rmon_pkg::IDX_EVT_MASK: begin
          evtMask <= wByte[1:0];
        end
        default: begin
        end
      endcase
    end
  end

  // Storage-only registers for the periodic timer and trim
  always_ff @(posedge clk) begin
    if (srst) begin
      perCtrl <= rmon_pkg::PER_CTRL_RESET;
      perTrim <= rmon_pkg::PER_TRIM_RESET;
      rateHi <= rmon_pkg::RATE_RESET;
      rateLo <= rmon_pkg::RATE_RESET;
      tempTrim <= rmon_pkg::TEMP_TRIM_RESET;
    end else if (wrEn) begin
      case (regIdx)
        rmon_pkg::IDX_PER_CTRL: perCtrl <= wByte & rmon_pkg::PER_CTRL_WMASK;
        rmon_pkg::IDX_PER_TRIM: perTrim <= wByte & rmon_pkg::PER_TRIM_WMASK;
        rmon_pkg::IDX_RATE_HI: rateHi <= wByte;
        rmon_pkg::IDX_RATE_LO: rateLo <= wByte;
        rmon_pkg::IDX_TEMP_TRIM: tempTrim <= wByte & rmon_pkg::TEMP_TRIM_WMASK;
        default: begin
        end
      endcase
    end
  end

  // Read mux; bits 1:0 of event status are the live flags
  logic [7:0] rByte;
  always_comb begin
    rByte = 8'h00;
    case (regIdx)
      rmon_pkg::IDX_TEMP_CTRL: rByte = {tempCtrl[7:3], overTempStatus,
        tempCtrl[rmon_pkg::IRQEN_BIT], overTempFlag};
      rmon_pkg::IDX_LV_CTRL: rByte = {5'h00, underVoltageStatus, lvIrqEnable,
        underVoltageFlag};
      rmon_pkg::IDX_PER_CTRL: rByte = perCtrl;
      rmon_pkg::IDX_PER_TRIM: rByte = perTrim;
      rmon_pkg::IDX_RATE_HI: rByte = rateHi;
      rmon_pkg::IDX_RATE_LO: rByte = rateLo;
      rmon_pkg::IDX_TEMP_TRIM: rByte = tempTrim;
      rmon_pkg::IDX_EVT_STATUS: rByte = {4'h0, mode == rmon_pkg::MODE_SHUTDOWN,
        mode == rmon_pkg::MODE_REDUCED, underVoltageFlag, overTempFlag};
      rmon_pkg::IDX_EVT_MASK: rByte = {6'h00, evtMask};
      default: rByte = 8'h00;
    endcase
  end

  // Read data registered so it only changes on a taken read
  always_ff @(posedge clk) begin
    if (srst) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= {24'h00_0000, rByte};
    end
  end

  // Analog route
  always_comb begin
    route.voltageSourceSelect = tempCtrl[rmon_pkg::SRC_SEL_BIT];
    route.voltageRouteEnable = tempCtrl[rmon_pkg::ROUTE_EN_BIT];
    route.tempSenseEnable = tempSenseOn;
  end

  assign overTempIrq = overTempFlag && tempCtrl[rmon_pkg::IRQEN_BIT];
  assign underVoltageIrq = underVoltageFlag && lvIrqEnable;
  assign irq = (overTempIrq && evtMask[0]) || (underVoltageIrq && evtMask[1]);

  a_flag_on_change: assert property (@(posedge clk) disable iff (srst)
    overTempChange |=> overTempFlag)
    else $error("temperature flag not set after change");
  a_lv_on_change: assert property (@(posedge clk) disable iff (srst)
    underVoltChange |=> underVoltageFlag)
    else $error("undervoltage flag not set after change");
  a_flag_sticky: assert property (@(posedge clk) disable iff (srst)
    (overTempFlag && !clrOverTemp) |=> overTempFlag)
    else $error("temperature flag dropped without clear");
  a_lv_clear: assert property (@(posedge clk) disable iff (srst)
    (clrUnderVolt && !underVoltChange) |=> !underVoltageFlag)
    else $error("undervoltage flag not cleared");
  a_ot_irq: assert property (@(posedge clk) disable iff (srst)
    (overTempChange && tempCtrl[rmon_pkg::IRQEN_BIT]
    && !(wrEn && regIdx == rmon_pkg::IDX_TEMP_CTRL)) |=> overTempIrq)
    else $error("temperature request mismatch");
  a_lv_irq: assert property (@(posedge clk) disable iff (srst)
    (underVoltChange && lvIrqEnable
    && !(wrEn && regIdx == rmon_pkg::IDX_LV_CTRL)) |=> underVoltageIrq)
    else $error("undervoltage request mismatch");
  a_status_low_mode: assert property (@(posedge clk) disable iff (srst)
    !fullMode |=> !underVoltageStatus && !overTempStatus)
    else $error("status set outside full mode");
  a_test_bits_locked: assert property (@(posedge clk) disable iff (srst)
    !testS |=> $stable(tempCtrl[7:6]))
    else $error("test bits changed outside test mode");
  a_shutdown_mode: assert property (@(posedge clk) disable iff (srst)
    !regEnS |-> mode == rmon_pkg::MODE_SHUTDOWN)
    else $error("not in shutdown while enable low");
  a_status_follow: assert property (@(posedge clk) disable iff (srst)
    fullMode && tempSenseOn && $stable(overTempS) |=> overTempStatus == $past(overTempS))
    else $error("temperature status does not follow detector");
  a_route_sel: assert property (@(posedge clk) disable iff (srst)
    (wrEn && regIdx == rmon_pkg::IDX_TEMP_CTRL)
    |=> route.voltageSourceSelect == $past(wByte[rmon_pkg::SRC_SEL_BIT]))
    else $error("source select mismatch");
  a_route_enable: assert property (@(posedge clk) disable iff (srst)
    (wrEn && regIdx == rmon_pkg::IDX_TEMP_CTRL)
    |=> route.voltageRouteEnable == $past(wByte[rmon_pkg::ROUTE_EN_BIT]))
    else $error("route enable mismatch");
  a_ot_irq_drop: assert property (@(posedge clk) disable iff (srst)
    (clrOverTemp && !overTempChange) |=> !overTempIrq)
    else $error("temperature request stayed after clear");
  a_lv_irq_drop: assert property (@(posedge clk) disable iff (srst)
    (wrEn && regIdx == rmon_pkg::IDX_LV_CTRL && !wByte[rmon_pkg::IRQEN_BIT])
    |=> !underVoltageIrq)
    else $error("undervoltage request stayed after disable");
  a_lv_sticky: assert property (@(posedge clk) disable iff (srst)
    (underVoltageFlag && !clrUnderVolt) |=> underVoltageFlag)
    else $error("undervoltage flag dropped without clear");
  a_ot_clear: assert property (@(posedge clk) disable iff (srst)
    (clrOverTemp && !overTempChange) |=> !overTempFlag)
    else $error("temperature flag not cleared");
  a_lv_follow: assert property (@(posedge clk) disable iff (srst)
    fullMode && $stable(underVoltS) |=> underVoltageStatus == $past(underVoltS))
    else $error("undervoltage status does not follow detector");
  a_detectors_off: assert property (@(posedge clk) disable iff (srst)
    !fullMode |-> detectorEnable == 2'h0)
    else $error("detector enabled outside full mode");
endmodule

// ==== verif/rmon_regs_tb_top.sv ====
// Self-checking testbench for the regulator monitor register bank
`timescale 1ns/1ps
module rmon_regs_tb_top;
  logic clk, srst, psel, penable, pwrite, pready, pslverr;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic regulatorEnable, stopMode, testMode, overTempIrq, underVoltageIrq, irq, err;
  logic [1:0] cmp, detectorEnable, irqs;
  rmon_pkg::rmon_cmp_t cmpRaw;
  rmon_pkg::rmon_route_t route;
  int fails, n_tests, cycles;
  logic [11:0] stIdx [5] = '{rmon_pkg::IDX_PER_CTRL, rmon_pkg::IDX_PER_TRIM,
    rmon_pkg::IDX_RATE_HI, rmon_pkg::IDX_RATE_LO, rmon_pkg::IDX_TEMP_TRIM};
  logic [7:0] stMask [5] = '{8'h9f, 8'hfc, 8'hff, 8'hff, 8'h8f};

  assign cmpRaw = cmp;
  assign irqs = {overTempIrq, underVoltageIrq};

  rmon_regs dut (.clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .regulator_enable_input(regulatorEnable), .stopMode(stopMode),
    .testMode(testMode), .cmpRaw(cmpRaw), .route(route), .detectorEnable(detectorEnable),
    .overTempIrq(overTempIrq), .underVoltageIrq(underVoltageIrq), .irq(irq));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Ceiling well above the few hundred cycles the sequence needs
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      wrap_up();
    end
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      $display("unexpected %s expected %h seen %h", name, exp, got);
      fails++;
    end
  endtask

  // One APB transfer; byte address is four times the register index
  task automatic apb(input logic w, input logic [11:0] idx, input logic [7:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h0, d};
    pstrb <= 4'hf;
    @(posedge clk);
    penable <= 1'b1;
    forever begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
  endtask

  task automatic rdchk(input string name, input logic [11:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    chk(name, {24'h0, exp}, rd);
  endtask

  task automatic settle();
    repeat (6) @(posedge clk);
  endtask

  // Full event path of one detector; b selects comparator and request
  task automatic evt(input string name, input logic [11:0] idx, input logic [7:0] en,
                     input int b);
    wr(idx, en);
    cmp[b] <= 1'b1;
    settle();
    rdchk(name, idx, en | 8'h05);
    chk("request", 32'h1, {31'h0, irqs[b]});
    chk("irq", 32'h1, {31'h0, irq});
    wr(idx, en | 8'h04);
    rdchk(name, idx, en | 8'h05);
    wr(idx, en | 8'h01);
    rdchk(name, idx, en | 8'h04);
    chk("request", 32'h0, {31'h0, irqs[b]});
    cmp[b] <= 1'b0;
    settle();
    rdchk(name, idx, en | 8'h01);
    wr(idx, en & 8'hfd);
    @(posedge clk);
    chk("request", 32'h0, {31'h0, irqs[b]});
    wr(idx, en);
    wr(rmon_pkg::IDX_EVT_MASK, 8'h00);
    @(posedge clk);
    chk("request", 32'h1, {31'h0, irqs[b]});
    chk("masked irq", 32'h0, {31'h0, irq});
    wr(rmon_pkg::IDX_EVT_MASK, 8'h03);
    wr(idx, en | 8'h01);
  endtask

  initial begin
    srst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 16'h0000;
    pwdata = 32'h0;
    pstrb = 4'h0;
    regulatorEnable = 1'b1;
    stopMode = 1'b0;
    testMode = 1'b0;
    cmp = 2'h0;
    fails = 0;
    n_tests = 0;
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    rdchk("temp ctrl", rmon_pkg::IDX_TEMP_CTRL, 8'h10);
    rdchk("lv ctrl", rmon_pkg::IDX_LV_CTRL, 8'h00);
    rdchk("evt status", rmon_pkg::IDX_EVT_STATUS, 8'h00);
    rdchk("mask", rmon_pkg::IDX_EVT_MASK, 8'h03);
    chk("mapped err", 32'h0, {31'h0, err});
    chk("pready", 32'h1, {31'h0, pready});
    for (int i = 0; i < 5; i++) begin
      rdchk("storage reset", stIdx[i], 8'h00);
      wr(stIdx[i], 8'hff);
      rdchk("storage mask", stIdx[i], stMask[i]);
    end
    wr(rmon_pkg::IDX_RSVD, 8'hff);
    chk("rsvd write err", 32'h1, {31'h0, err});
    rdchk("rsvd read", rmon_pkg::IDX_RSVD, 8'h00);
    chk("rsvd read err", 32'h1, {31'h0, err});
    apb(1'b0, 12'h300, 8'h00);
    chk("unmapped err", 32'h1, {31'h0, err});
    // Every select, route and sense combination, test bits locked out
    for (int i = 0; i < 8; i++) begin
      wr(rmon_pkg::IDX_TEMP_CTRL, {2'b11, i[2:0], 3'b000});
      @(posedge clk);
      chk("route", {29'h0, i[1], i[2], i[0]}, {29'h0, route});
      rdchk("temp ctrl", rmon_pkg::IDX_TEMP_CTRL, {2'b00, i[2:0], 3'b000});
    end
    testMode <= 1'b1;
    repeat (3) @(posedge clk);
    wr(rmon_pkg::IDX_TEMP_CTRL, 8'hca);
    rdchk("test bits", rmon_pkg::IDX_TEMP_CTRL, 8'hca);
    wr(rmon_pkg::IDX_TEMP_CTRL, 8'h0a);
    testMode <= 1'b0;
    evt("temp ctrl", rmon_pkg::IDX_TEMP_CTRL, 8'h0a, 1);
    evt("lv ctrl", rmon_pkg::IDX_LV_CTRL, 8'h02, 0);
    // Reduced power: flags kept, status forced low, detectors off
    cmp <= 2'b11;
    settle();
    stopMode <= 1'b1;
    settle();
    rdchk("temp ctrl", rmon_pkg::IDX_TEMP_CTRL, 8'h0b);
    rdchk("lv ctrl", rmon_pkg::IDX_LV_CTRL, 8'h03);
    rdchk("evt status", rmon_pkg::IDX_EVT_STATUS, 8'h07);
    chk("detectors", 32'h0, {30'h0, detectorEnable});
    wr(rmon_pkg::IDX_TEMP_CTRL, 8'h0b);
    wr(rmon_pkg::IDX_LV_CTRL, 8'h03);
    cmp <= 2'b00;
    settle();
    rdchk("temp ctrl", rmon_pkg::IDX_TEMP_CTRL, 8'h0a);
    rdchk("lv ctrl", rmon_pkg::IDX_LV_CTRL, 8'h02);
    stopMode <= 1'b0;
    settle();
    // Regulator enable low means shutdown
    regulatorEnable <= 1'b0;
    settle();
    rdchk("evt status", rmon_pkg::IDX_EVT_STATUS, 8'h08);
    chk("detectors", 32'h0, {30'h0, detectorEnable});
    cmp <= 2'b01;
    settle();
    rdchk("lv ctrl", rmon_pkg::IDX_LV_CTRL, 8'h02);
    cmp <= 2'b00;
    regulatorEnable <= 1'b1;
    settle();
    chk("detectors", 32'h3, {30'h0, detectorEnable});
    rdchk("evt status", rmon_pkg::IDX_EVT_STATUS, 8'h00);
    wrap_up();
  end
endmodule
